// *** ext_irq_edge_noise_ctrl.sv ***
`timescale 1ns/1ps
`include "ext_irq_defs.svh"

// How it works
// (RQ1) second input drops pulses under 63 clocks, or 15 when select set
// (RQ2) select bit 0 gives pin to port, 1 makes it first interrupt input
// (RQ3) software sets the shared port bit to input before interrupt use
// (RQ4) third/fourth modes: 00 rise, 01 fall, 10 both, 11 high level
// (RQ5) second input polarity: 0 rising edge, 1 falling edge
// (RQ6) new filter length applies within 26 clocks of the write
// (RQ7) high-level mode waits for a rising edge after reset release
// (RQ8) software masks interrupts while changing clocks or this register
// (RQ9) second input accepts pulses of 49 or 193 clocks
// (RQ10) with select bit 0 a falling edge on shared pin raises nothing
// (RQ11) third/fourth inputs drop pulses under 7 and take 25 or more
// (RQ12) slow mode drops pulses under one slow period, takes 3.5
// (RQ13) inputs synchronised; each qualified edge gives a one-cycle request, high-level mode requests while high

module ext_irq_edge_noise_ctrl #(
    parameter int SLOW_DIV = 6103
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [5:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic slow_mode,
    input wire logic first_irq_input,
    input wire logic second_irq_input,
    input wire logic third_irq_input,
    input wire logic fourth_irq_input,
    output logic shared_pin_port_mode,
    output logic first_irq_req,
    output logic second_irq_req,
    output logic third_irq_req,
    output logic fourth_irq_req
);

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    logic [7:0] ext_irq_trigger_config_r;

    wire cfg_hit = (sfr_addr == `TRIG_CFG_ADDR);
    wire cfg_wr = sfr_wr && cfg_hit;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ext_irq_trigger_config_r <= `TRIG_CFG_RESET;
        end else if (cfg_wr) begin
            ext_irq_trigger_config_r <= sfr_wdata & `CFG_USED_MASK;
        end
    end

    // read data is combinational, so a read needs no wait state;
    // bit 0 has no storage and always reads 0
    assign sfr_rdata = cfg_hit ? ext_irq_trigger_config_r : 8'h00;

    wire second_input_filter_length =
        ext_irq_trigger_config_r[`SECOND_FILT_LEN_BIT];
    wire shared_pin_irq_select = ext_irq_trigger_config_r[`SHARED_SEL_BIT];
    wire second_input_edge_polarity =
        ext_irq_trigger_config_r[`SECOND_POL_BIT];
    ext_irq_pkg::trig_mode_type third_input_trigger_mode;
    ext_irq_pkg::trig_mode_type fourth_input_trigger_mode;
    assign third_input_trigger_mode = ext_irq_pkg::trig_mode_type'(
        ext_irq_trigger_config_r[`THIRD_MODE_HI:`THIRD_MODE_LO]);
    assign fourth_input_trigger_mode = ext_irq_pkg::trig_mode_type'(
        ext_irq_trigger_config_r[`FOURTH_MODE_HI:`FOURTH_MODE_LO]);

    // outside port logic owns the pin while this is high
    // (RQ2) pin function select
    assign shared_pin_port_mode = !shared_pin_irq_select;

    // ----------------------------------------------------------------
    // slow clock enable
    // ----------------------------------------------------------------
    // free-running; the filters use the tick only while slow_mode is high
    logic [15:0] slow_div_r;
    wire slow_tick = (slow_div_r == 16'(SLOW_DIV - 1));

    always_ff @(posedge core_clk) begin
        if (!reset_n || slow_tick) begin
            slow_div_r <= 16'h0000;
        end else begin
            slow_div_r <= slow_div_r + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // noise filters
    // ----------------------------------------------------------------
    // (RQ6) length select is read combinationally, so it acts at once
    // (RQ9) accepted length follows the select
    wire [7:0] second_thresh = second_input_filter_length ?
        `SECOND_SHORT_REJECT_FC : `SECOND_LONG_REJECT_FC;

    // one filter per input; only the reject lengths differ
    logic [3:0] pins;
    logic [3:0] filt;
    logic [31:0] thresh_flat;
    assign pins = {fourth_irq_input, third_irq_input,
                   second_irq_input, first_irq_input};
    // (RQ11) third/fourth lengths
    assign thresh_flat = {`THIRD_FOURTH_REJECT_FC, `THIRD_FOURTH_REJECT_FC,
                          second_thresh, `FIRST_REJECT_FC};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_filt
            // (RQ12) slow mode counts slow periods
            irq_noise_filter #(.CW(8)) u_filt (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .pin_async(pins[gi]),
                .fast_thresh(thresh_flat[gi*8 +: 8]),
                .slow_thresh(`SLOW_REJECT_FS),
                .slow_mode(slow_mode),
                .slow_tick(slow_tick),
                .level(filt[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // start-up mask
    // ----------------------------------------------------------------
    // the filters adopt the pin level three clocks after reset and the
    // edge register follows one clock later; until then a pin that was
    // already high would look like a rising edge
    // (RQ7) no edge counts before the filters have settled
    logic [2:0] settle_r;
    wire settled = (settle_r == `EDGE_SETTLE_CYCLES);

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            settle_r <= 3'h0;
        end else if (!settled) begin
            settle_r <= settle_r + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    logic [3:0] filt_d_r;
    logic [3:0] armed_r;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            filt_d_r <= 4'h0;
        end else begin
            filt_d_r <= filt;
        end
    end

    wire [3:0] rise = filt & ~filt_d_r & {4{settled}};
    wire [3:0] fall = ~filt & filt_d_r & {4{settled}};

    // armed bits clear only on reset: once armed, a high level keeps asking
    // (RQ7) level mode armed only by a rising edge after reset
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            armed_r <= 4'h0;
        end else begin
            armed_r <= armed_r | rise;
        end
    end

    // ----------------------------------------------------------------
    // trigger decode
    // ----------------------------------------------------------------
    // the level case also fires on the arming edge itself, one clock
    // sooner than waiting for armed_r to be set
    function automatic logic trig_hit(
        input ext_irq_pkg::trig_mode_type mode,
        input logic r,
        input logic f,
        input logic lvl,
        input logic armed
    );
        case (mode)
            ext_irq_pkg::TRIG_RISE: trig_hit = r;
            ext_irq_pkg::TRIG_FALL: trig_hit = f;
            ext_irq_pkg::TRIG_BOTH: trig_hit = r | f;
            default: trig_hit = lvl & (armed | r);
        endcase
    endfunction

    // (RQ10) falling edge counts only when the pin is an interrupt input
    wire first_hit = fall[0] && shared_pin_irq_select;
    // (RQ5) second input polarity
    wire second_hit = second_input_edge_polarity ? fall[1] : rise[1];
    // (RQ4) trigger mode decode
    wire third_hit = trig_hit(third_input_trigger_mode, rise[2], fall[2],
                              filt[2], armed_r[2]);
    wire fourth_hit = trig_hit(fourth_input_trigger_mode, rise[3], fall[3],
                               filt[3], armed_r[3]);

    // ----------------------------------------------------------------
    // request outputs
    // ----------------------------------------------------------------
    // registered so the latch outside never sees a decode glitch
    // (RQ13) registered requests, one cycle per edge; held while high in level mode
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            first_irq_req <= 1'b0;
            second_irq_req <= 1'b0;
            third_irq_req <= 1'b0;
            fourth_irq_req <= 1'b0;
        end else begin
            first_irq_req <= first_hit;
            second_irq_req <= second_hit;
            third_irq_req <= third_hit;
            fourth_irq_req <= fourth_hit;
        end
    end

endmodule // ext_irq_edge_noise_ctrl

// *** ext_irq_defs.svh ***
`ifndef EXT_IRQ_DEFS_SVH
`define EXT_IRQ_DEFS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define TRIG_CFG_ADDR 6'h37
`define TRIG_CFG_RESET 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SECOND_FILT_LEN_BIT 7
`define SHARED_SEL_BIT 6
`define THIRD_MODE_HI 5
`define THIRD_MODE_LO 4
`define FOURTH_MODE_HI 3
`define FOURTH_MODE_LO 2
`define SECOND_POL_BIT 1
`define CFG_USED_MASK 8'hFE

// ----------------------------------------------------------------
// noise-reject lengths, in fast clock periods (core_clk = fast clock)
// ----------------------------------------------------------------
`define FIRST_REJECT_FC 8'h02
`define SECOND_LONG_REJECT_FC 8'h3F
`define SECOND_SHORT_REJECT_FC 8'h0F
`define THIRD_FOURTH_REJECT_FC 8'h07
// in slow-clock periods
`define SLOW_REJECT_FS 8'h02

// ----------------------------------------------------------------
// start-up: filter priming clocks, then clocks until edges count
// ----------------------------------------------------------------
`define FILT_PRIME_CYCLES 2'h3
`define EDGE_SETTLE_CYCLES 3'h4

`endif

// *** ext_irq_pkg.sv ***
package ext_irq_pkg;

    typedef enum logic [1:0] {
        TRIG_RISE = 2'h0,
        TRIG_FALL = 2'h1,
        TRIG_BOTH = 2'h2,
        TRIG_HIGH = 2'h3
    } trig_mode_type;

endpackage

// *** irq_noise_filter.sv ***
`timescale 1ns/1ps
`include "ext_irq_defs.svh"

module irq_noise_filter #(
    parameter int CW = 8
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic pin_async,
    input wire logic [CW-1:0] fast_thresh,
    input wire logic [CW-1:0] slow_thresh,
    input wire logic slow_mode,
    input wire logic slow_tick,
    output logic level
);

    logic sync1_r;
    logic sync2_r;
    logic [1:0] prime_r;
    logic [CW-1:0] cnt_r;

    wire primed = (prime_r == `FILT_PRIME_CYCLES);
    wire step = slow_mode ? slow_tick : 1'b1;
    wire [CW-1:0] thresh = slow_mode ? slow_thresh : fast_thresh;
    wire [CW-1:0] cnt_inc = cnt_r + {{(CW-1){1'b0}}, 1'b1};

    // (RQ13) two-stage synchroniser
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_async;
            sync2_r <= sync1_r;
        end
    end

    // the first settled sample is taken as the starting level, so a pin
    // already high at reset release lifts level from 0 at once, like a rising edge
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prime_r <= 2'h0;
            cnt_r <= '0;
            level <= 1'b0;
        end else if (!primed) begin
            prime_r <= prime_r + 2'h1;
            level <= sync2_r;
        end else if (sync2_r == level) begin
            cnt_r <= '0;
        end else if (step) begin
            // (RQ1) stable-length reject
            if (cnt_inc >= thresh) begin
                level <= sync2_r;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_inc;
            end
        end
    end

endmodule // irq_noise_filter

// *** board_pins.sv ***
`timescale 1ns/1ps
module board_pins (
    input wire logic core_clk,
    output logic [3:0] pins
);
    // first pin idles high: it is pulled up and taken on falling edges
    initial pins = 4'h1;
    task automatic put(input int i, input logic v);
        pins[i] = v;
    endtask
    // hold pin i at the opposite level for exactly w clocks
    task automatic pulse(input int i, input int w);
        @(posedge core_clk);
        #1 pins[i] = !pins[i];
        repeat (w) @(posedge core_clk);
        #1 pins[i] = !pins[i];
    endtask
endmodule // board_pins

// *** ext_irq_asserts.sv ***
`timescale 1ns/1ps
module ext_irq_asserts (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [5:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic slow_mode,
    input wire logic second_irq_input,
    input wire logic third_irq_input,
    input wire logic shared_pin_port_mode,
    input wire logic first_irq_req,
    input wire logic second_irq_req,
    input wire logic third_irq_req
);
    // shadow of the control register, rebuilt from the writes
    logic [7:0] cfg_r;
    always_ff @(posedge core_clk) begin
        if (!reset_n) cfg_r <= 8'h00;
        else if (sfr_wr && sfr_addr == 6'h37) cfg_r <= sfr_wdata & 8'hFE;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_cfg_wr;
        sfr_wr && sfr_addr == 6'h37;
    endsequence
    a_write_seen: assert property (s_cfg_wr ##1 sfr_addr == 6'h37
        |-> sfr_rdata == ($past(sfr_wdata, 1) & 8'hFE))
        else $error("written value not read back");
    a_unmapped_zero: assert property (sfr_addr != 6'h37
        |-> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    a_port_mode: assert property (
        shared_pin_port_mode == !cfg_r[6]) else $error("port mode wrong");
    a_reset_quiet: assert property (disable iff (1'b0) !reset_n
        |=> !first_irq_req && !second_irq_req && !third_irq_req
        && shared_pin_port_mode) else $error("reset state wrong");
    a_first_gated: assert property (first_irq_req |-> cfg_r[6])
        else $error("first request while pin is port");
    a_second_single: assert property (second_irq_req
        |=> !second_irq_req) else $error("second request too long");
    a_third_single: assert property (third_irq_req
        && cfg_r[5:4] != 2'h3 |=> !third_irq_req)
        else $error("third edge request too long");
    a_second_stable: assert property ($rose(second_irq_req)
        && !slow_mode
        |-> $past(second_irq_input, 4) == $past(second_irq_input, 17))
        else $error("second request after short pulse");
    a_third_stable: assert property ($rose(third_irq_req)
        && cfg_r[5:4] != 2'h3
        |-> $past(third_irq_input, 4) == $past(third_irq_input, 8))
        else $error("third request after short pulse");
endmodule // ext_irq_asserts

bind ext_irq_edge_noise_ctrl ext_irq_asserts ext_irq_asserts_inst (
    .core_clk, .reset_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
    .slow_mode, .second_irq_input, .third_irq_input, .shared_pin_port_mode,
    .first_irq_req, .second_irq_req, .third_irq_req);

// *** ext_irq_edge_noise_ctrl_tb.sv ***
`timescale 1ns/1ps
module ext_irq_edge_noise_ctrl_tb;
    logic core_clk, reset_n, sfr_wr, slow_mode, pmode;
    logic [5:0] sfr_addr;
    logic [7:0] sfr_wdata, rd, d;
    logic [3:0] pins, req;
    int err_count, total_checks, seed, cnt, sel, w;
    board_pins board_pins_inst (.core_clk, .pins);
    ext_irq_edge_noise_ctrl #(.SLOW_DIV(4)) ext_irq_edge_noise_ctrl_inst (
        .core_clk, .reset_n, .sfr_addr, .sfr_wr, .sfr_wdata,
        .sfr_rdata(rd), .slow_mode, .first_irq_input(pins[0]),
        .second_irq_input(pins[1]), .third_irq_input(pins[2]),
        .fourth_irq_input(pins[3]), .shared_pin_port_mode(pmode),
        .first_irq_req(req[0]), .second_irq_req(req[1]),
        .third_irq_req(req[2]), .fourth_irq_req(req[3]));
    initial begin
        core_clk = 0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (req[sel] === 1'b1) cnt++;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge core_clk);
        #1 sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1;
        @(posedge core_clk);
        #1 sfr_wr = 0;
        sfr_addr = 6'h37;
    endtask
    // the window is long enough for the slowest filter to settle
    task automatic trial(input int i, input int pw, input int e);
        sel = i;
        cnt = 0;
        board_pins_inst.pulse(i, pw);
        repeat (300) @(posedge core_clk);
        #1;
        chk(cnt[7:0], e[7:0]);
    endtask
    task automatic step(input int i, input logic v, input int e);
        sel = i;
        cnt = 0;
        @(posedge core_clk);
        #1 board_pins_inst.put(i, v);
        repeat (300) @(posedge core_clk);
        #1;
        chk(cnt[7:0], e[7:0]);
    endtask
    function automatic int model(int m, int pw, int n);
        if (pw < n) return 0;
        if (m == 3) return pw;
        return (m == 2) ? 2 : 1;
    endfunction
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge core_clk);
        err_count++;
        conclude();
    end
    initial begin
        seed = 32'h720f2956;
        {err_count, total_checks, cnt, sel} = 0;
        {reset_n, sfr_wr, slow_mode} = 3'h0;
        sfr_addr = 6'h37;
        sfr_wdata = 8'h00;
        repeat (8) @(posedge core_clk);
        #1 reset_n = 1;
        chk(rd, 8'h00);
        chk({7'h0, pmode}, 8'h01);
        d = $random(seed);
        wr(6'h12, d);
        chk(rd, 8'h00);
        wr(6'h37, d);
        chk(rd, d & 8'hFE);
        chk({7'h0, pmode}, {7'h0, !d[6]});
        $display("test registers done");
        for (int b = 0; b < 2; b++) begin
            wr(6'h37, b ? 8'h40 : 8'h00);
            trial(0, 10, b);
        end
        $display("test shared pin done");
        for (int m = 0; m < 4; m++) begin
            wr(6'h37, 8'(m * 20));
            for (int i = 2; i < 4; i++) begin
                w = 25 + ($random(seed) & 7);
                trial(i, w, model(m, w, 7));
                trial(i, 6, 0);
            end
        end
        $display("test trigger modes done");
        for (int k = 0; k < 4; k++) begin
            wr(6'h37, {k[1], 5'h0, k[0], 1'b0});
            w = k[1] ? 15 : 63;
            trial(1, w + 4, 1);
            trial(1, w - 1, 0);
            trial(1, k[1] ? 49 : 193, 1);
            step(1, 1'b1, !k[0]);
            step(1, 1'b0, k[0]);
        end
        $display("test second input done");
        wr(6'h37, 8'h00);
        slow_mode = 1;
        trial(2, 3, 0);
        trial(2, 14, 1);
        slow_mode = 0;
        $display("test slow mode done");
        board_pins_inst.put(2, 1);
        repeat (20) @(posedge core_clk);
        #1 reset_n = 0;
        repeat (8) @(posedge core_clk);
        #1 reset_n = 1;
        wr(6'h37, 8'h30);
        step(2, 1'b1, 0);
        step(2, 1'b0, 0);
        // level request stands once sync, 7-clock filter, request register pass
        step(2, 1'b1, 300 - 3 - 7);
        chk({7'h0, cnt > 200}, 8'h01);
        $display("test level after reset done");
        conclude();
    end
endmodule // ext_irq_edge_noise_ctrl_tb
